// >>> axfl_axis_channel.sv
`timescale 1ns/10ps
`include "axfl_regs.svh"

module axfl_axis_channel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // motor and drive side, asynchronous
  input wire logic sineIn,
  input wire logic cosineIn,
  input wire logic markerIn,
  input wire axfl_pkg::axfl_hall_type hallIn,
  input wire logic cwLimitIn,
  input wire logic ccwLimitIn,
  input wire logic homeLimitIn,
  input wire logic driveFaultIn,
  // controller side, asynchronous
  input wire logic enableNIn,
  // controller side outputs
  output logic sineP,
  output logic sineN,
  output logic cosineP,
  output logic cosineN,
  output logic markerP,
  output logic markerN,
  output axfl_pkg::axfl_hall_type hallOut,
  output logic cwLimitOut,
  output logic ccwLimitOut,
  output logic homeLimitOut,
  output logic faultN,
  output logic hallCodeBad,
  // drive side output
  output logic driveEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser
  logic [`AXFL_BUNDLE_W-1:0] rawIn;
  logic [`AXFL_BUNDLE_W-1:0] syncA;
  logic [`AXFL_BUNDLE_W-1:0] syncB;
  logic [`AXFL_BUNDLE_W-1:0] next_syncA;
  logic [`AXFL_BUNDLE_W-1:0] next_syncB;

  assign rawIn = {enableNIn, driveFaultIn, homeLimitIn, ccwLimitIn, cwLimitIn,
                  hallIn, markerIn, cosineIn, sineIn};

  // syncA feeds syncB only; nothing else may look at it
  always_comb begin
    next_syncA = rawIn;
    next_syncB = syncA;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA <= `AXFL_BUNDLE_RST;
      syncB <= `AXFL_BUNDLE_RST;
    end else begin
      syncA <= next_syncA;
      syncB <= next_syncB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage
  logic next_sine;
  logic next_cosine;
  logic next_marker;
  axfl_pkg::axfl_hall_type next_hall;
  logic next_cw;
  logic next_ccw;
  logic next_home;
  logic next_faultN;
  logic next_hallBad;
  logic next_driveEnable;

  // each pair comes from one flop value so both halves switch on the same edge
  always_comb begin
    next_sine = syncB[`AXFL_POS_SINE];
    next_cosine = syncB[`AXFL_POS_COSINE];
    next_marker = syncB[`AXFL_POS_MARKER];
    next_hall = syncB[`AXFL_POS_HALL_HI:`AXFL_POS_HALL_LO];
    next_cw = syncB[`AXFL_POS_CW];
    next_ccw = syncB[`AXFL_POS_CCW];
    next_home = syncB[`AXFL_POS_HOME];
    next_faultN = ~syncB[`AXFL_POS_FAULT];
    next_hallBad = (next_hall == `AXFL_HALL_ALL_LOW) || (next_hall == `AXFL_HALL_ALL_HIGH);
    next_driveEnable = ~syncB[`AXFL_POS_ENABLE_N];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sineP <= 1'b0;
      sineN <= 1'b1;
      cosineP <= 1'b0;
      cosineN <= 1'b1;
      markerP <= 1'b0;
      markerN <= 1'b1;
      hallOut <= 3'h0;
      cwLimitOut <= 1'b0;
      ccwLimitOut <= 1'b0;
      homeLimitOut <= 1'b0;
      faultN <= 1'b1;
      hallCodeBad <= 1'b0;
      driveEnable <= 1'b0;
    end else begin
      sineP <= next_sine;
      sineN <= ~next_sine;
      cosineP <= next_cosine;
      cosineN <= ~next_cosine;
      markerP <= next_marker;
      markerN <= ~next_marker;
      hallOut <= next_hall;
      cwLimitOut <= next_cw;
      ccwLimitOut <= next_ccw;
      homeLimitOut <= next_home;
      faultN <= next_faultN;
      hallCodeBad <= next_hallBad;
      driveEnable <= next_driveEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] settleCnt;
  logic [1:0] next_settleCnt;
  logic [1:0] settle;
  logic [1:0] next_settle;

  // counts edges since reset so past values are valid; checks use a registered
  // copy, since disable iff reads current values and the bare count would arm
  // them one edge before the oldest sampled output has left reset
  always_comb begin
    next_settleCnt = (settleCnt == `AXFL_SETTLE_CYC) ? settleCnt : settleCnt + 2'h1;
    next_settle = settleCnt;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settleCnt <= 2'h0;
      settle <= 2'h0;
    end else begin
      settleCnt <= next_settleCnt;
      settle <= next_settle;
    end
  end

  sine_pair_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    (sineP != sineN) && (sineP == $past(sineIn, 3)))
    else $error("sine pair not complementary or late");

  cosine_pair_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    (cosineP != cosineN) && (cosineP == $past(cosineIn, 3)))
    else $error("cosine pair not complementary or late");

  marker_pair_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    $rose(markerIn) |-> ##3 (markerP && !markerN))
    else $error("marker pulse not passed");

  hall_pass_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    hallOut == $past(hallIn, 3))
    else $error("hall lines not passed");

  limit_pass_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    {cwLimitOut, ccwLimitOut, homeLimitOut} ==
    $past({cwLimitIn, ccwLimitIn, homeLimitIn}, 3))
    else $error("limit switch not passed");

  enable_low_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    enableNIn [*3] |=> !driveEnable)
    else $error("drive enabled while enable line high");

  fault_low_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    faultN == !$past(driveFaultIn, 3))
    else $error("fault output wrong level");

endmodule : axfl_axis_channel

// >>> axfl_ctrl_model.sv
`timescale 1ns/10ps
`include "axfl_regs.svh"

module axfl_ctrl_model #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench commands
  input wire logic sendLevel,
  input wire logic syncOn,
  input wire logic [NUM_AXES-1:0] enableNCmd,
  input wire logic homeCycle,
  // controller pins toward the chassis
  output logic interlockSend,
  output logic ampSyncIn,
  output logic [NUM_AXES-1:0] enableNIn,
  // feedback from the chassis
  input wire logic interlockReceive,
  input wire logic [NUM_AXES-1:0] sineP,
  input wire logic [NUM_AXES-1:0] sineN,
  input wire logic [NUM_AXES-1:0] cosineP,
  input wire logic [NUM_AXES-1:0] cosineN,
  input wire logic [NUM_AXES-1:0] cwLimitOut,
  input wire logic [NUM_AXES-1:0] ccwLimitOut,
  input wire logic [NUM_AXES-1:0] markerP,
  input wire logic [NUM_AXES-1:0] homeLimitOut,
  // verdicts of the controller
  output logic chassisPresent,
  output logic [NUM_AXES-1:0] encoderLoss,
  output logic [NUM_AXES-1:0] cwBlock,
  output logic [NUM_AXES-1:0] ccwBlock,
  output logic [NUM_AXES-1:0] homeFound,
  output logic [NUM_AXES-1:0][7:0] position
);
  localparam int HALF_CYC = `AXFL_SYNC_PERIOD_CYC / 2;
  int phase = 0;
  logic [2:0] sendHist = 3'h0;

  // pins change just after the edge, like the real controller; commands are
  // read at the edge itself so they never race the bench's own updates
  always @(posedge sys_clk) begin
    interlockSend <= #1 sendLevel;
    enableNIn <= #1 enableNCmd;
    if (rst || !syncOn) begin
      phase <= 0;
      ampSyncIn <= #1 1'b0;
    end else if (phase == HALF_CYC - 1) begin
      phase <= 0;
      ampSyncIn <= #1 ~ampSyncIn;
    end else begin
      phase <= phase + 1;
    end
  end

  // feedback passes two flops before decoding; sinC and cosC hold the
  // previous decoded state for edge detection
  logic [NUM_AXES-1:0] sinA, sinB, sinC, cosA, cosB, cosC, mkA, mkB, homA, homB;

  always @(posedge sys_clk) begin
    {sinA, cosA, mkA, homA} <= {sineP, cosineP, markerP, homeLimitOut};
    {sinB, cosB, mkB, homB} <= {sinA, cosA, mkA, homA};
    {sinC, cosC} <= {sinB, cosB};
  end

  // quadrature edges move the count; the home switch only arms the search
  // inside the home cycle, and the next marker then zeroes the count
  always @(posedge sys_clk) begin
    for (int a = 0; a < NUM_AXES; a++) begin
      if (rst || !homeCycle) begin
        homeFound[a] <= 1'b0;
      end else if (homB[a]) begin
        homeFound[a] <= 1'b1;
      end
      if (rst) begin
        position[a] <= 8'h00;
      end else if (homeCycle && homeFound[a] && mkB[a]) begin
        position[a] <= 8'h00;
      end else if (sinB[a] ^ sinC[a] ^ cosB[a] ^ cosC[a]) begin
        // forward when the new sine differs from the old cosine
        position[a] <= (sinB[a] ^ cosC[a]) ? position[a] + 8'h01 :
                                             position[a] - 8'h01;
      end
    end
  end

  // returned copy must match what was sent three edges back
  always @(posedge sys_clk) begin
    sendHist <= {sendHist[1:0], interlockSend};
    chassisPresent <= (interlockReceive === sendHist[2]);
  end

  // marker pairs are left out of the loss check
  assign encoderLoss = ~((sineP ^ sineN) & (cosineP ^ cosineN));
  assign cwBlock = cwLimitOut;
  assign ccwBlock = ccwLimitOut;
endmodule : axfl_ctrl_model

// >>> axfl_pkg.sv
package axfl_pkg;

  // one hall triplet, bit 0 = A, bit 1 = B, bit 2 = C
  typedef logic [2:0] axfl_hall_type;

  // how the amplifier sync pin is strapped
  typedef enum logic {
    SYNC_DRIVEN,
    SYNC_COMMON
  } axfl_sync_mode_type;

endpackage : axfl_pkg

// >>> axfl_regs.svh
`ifndef AXFL_REGS_SVH
`define AXFL_REGS_SVH

// channel count and synchroniser depth
`define AXFL_NUM_AXES 4
`define AXFL_SYNC_STAGES 2

// bit positions inside the per-axis input bundle
`define AXFL_POS_SINE 0
`define AXFL_POS_COSINE 1
`define AXFL_POS_MARKER 2
`define AXFL_POS_HALL_LO 3
`define AXFL_POS_HALL_HI 5
`define AXFL_POS_CW 6
`define AXFL_POS_CCW 7
`define AXFL_POS_HOME 8
`define AXFL_POS_FAULT 9
`define AXFL_POS_ENABLE_N 10
`define AXFL_BUNDLE_W 11

// bundle reset: enable line idles high so the drive stays off
`define AXFL_BUNDLE_RST 11'h400

// illegal hall codes: all low or all high
`define AXFL_HALL_ALL_LOW 3'h0
`define AXFL_HALL_ALL_HIGH 3'h7

// pin-to-pin latency: two synchroniser stages plus the output flop
`define AXFL_SETTLE_CYC 2'h3

// timing: system clock, nominal sync rate and sync loss window
`define AXFL_CLK_FREQ_KHZ 10000
`define AXFL_SYNC_FREQ_KHZ 20
`define AXFL_SYNC_PERIOD_CYC (`AXFL_CLK_FREQ_KHZ / `AXFL_SYNC_FREQ_KHZ)
`define AXFL_SYNC_LOSS_US 100
`define AXFL_SYNC_LOSS_CYC ((`AXFL_SYNC_LOSS_US * `AXFL_CLK_FREQ_KHZ) / 1000)
`define AXFL_SYNC_CNT_W 11

`endif

// >>> axfl_top.sv
`timescale 1ns/10ps
`include "axfl_regs.svh"

// Overview of operation
// - chassis loops interlock send back onto interlock receive
// - sync pin may be strapped as common; drives never depend on it
// - four identical independent axis channels of encoder, hall, limit, home
// - sine given as complementary high and low pair, quadrature square wave
// - cosine given as complementary pair in quadrature with sine
// - marker given as complementary pair, once per motor revolution
// - three hall lines A, B, C given per axis
// - cw, ccw and home switch signals passed through to controller
// - axis enable is active low; high or open disables the drive
// - axis fault output goes low on a drive fault, high otherwise
module axfl_top #(
  parameter int NUM_AXES = `AXFL_NUM_AXES,
  parameter int SYNC_LOSS_CYC = `AXFL_SYNC_LOSS_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // controller link, asynchronous
  input wire logic interlockSend,
  input wire logic ampSyncIn,
  input wire logic syncStrapCommon,
  input wire logic [NUM_AXES-1:0] enableNIn,
  // motor and drive side, asynchronous
  input wire logic [NUM_AXES-1:0] sineIn,
  input wire logic [NUM_AXES-1:0] cosineIn,
  input wire logic [NUM_AXES-1:0] markerIn,
  input wire axfl_pkg::axfl_hall_type [NUM_AXES-1:0] hallIn,
  input wire logic [NUM_AXES-1:0] cwLimitIn,
  input wire logic [NUM_AXES-1:0] ccwLimitIn,
  input wire logic [NUM_AXES-1:0] homeLimitIn,
  input wire logic [NUM_AXES-1:0] driveFaultIn,
  // controller link outputs
  output logic interlockReceive,
  output logic [NUM_AXES-1:0] sineP,
  output logic [NUM_AXES-1:0] sineN,
  output logic [NUM_AXES-1:0] cosineP,
  output logic [NUM_AXES-1:0] cosineN,
  output logic [NUM_AXES-1:0] markerP,
  output logic [NUM_AXES-1:0] markerN,
  output axfl_pkg::axfl_hall_type [NUM_AXES-1:0] hallOut,
  output logic [NUM_AXES-1:0] cwLimitOut,
  output logic [NUM_AXES-1:0] ccwLimitOut,
  output logic [NUM_AXES-1:0] homeLimitOut,
  output logic [NUM_AXES-1:0] faultN,
  // drive side outputs
  output logic [NUM_AXES-1:0] driveEnable,
  output logic ampSyncToDrives,
  // status
  output logic syncActive,
  output logic [NUM_AXES-1:0] hallCodeBad
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the chassis-wide pins
  logic [2:0] pinA;
  logic [2:0] pinB;
  logic [2:0] next_pinA;
  logic [2:0] next_pinB;

  // pinA is read by pinB alone
  always_comb begin
    next_pinA = {syncStrapCommon, ampSyncIn, interlockSend};
    next_pinB = pinA;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinA <= 3'h0;
      pinB <= 3'h0;
    end else begin
      pinA <= next_pinA;
      pinB <= next_pinB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interlock loop and sync handling
  axfl_pkg::axfl_sync_mode_type syncMode;
  axfl_pkg::axfl_sync_mode_type next_syncMode;
  logic syncLast;
  logic next_syncLast;
  logic [`AXFL_SYNC_CNT_W-1:0] sinceEdge;
  logic [`AXFL_SYNC_CNT_W-1:0] next_sinceEdge;
  logic next_interlock;
  logic next_ampSync;
  logic next_syncActive;
  logic syncEdge;

  // strap is followed continuously; it is meant to be static
  always_comb begin
    next_syncMode = pinB[2] ? axfl_pkg::SYNC_COMMON : axfl_pkg::SYNC_DRIVEN;
    next_syncLast = pinB[1];
    syncEdge = pinB[1] != syncLast;
    next_interlock = pinB[0];
    // common strap grounds the drive-side sync instead of passing it
    next_ampSync = (syncMode == axfl_pkg::SYNC_COMMON) ? 1'b0 : pinB[1];
    // saturating count of cycles since the last sync edge
    if (syncEdge || syncMode == axfl_pkg::SYNC_COMMON) begin
      next_sinceEdge = '0;
    end else if (sinceEdge == `AXFL_SYNC_CNT_W'(SYNC_LOSS_CYC)) begin
      next_sinceEdge = sinceEdge;
    end else begin
      next_sinceEdge = sinceEdge + `AXFL_SYNC_CNT_W'(1);
    end
    // status only; nothing on the drive path waits for it
    next_syncActive = (syncMode == axfl_pkg::SYNC_DRIVEN) &&
                      (next_sinceEdge != `AXFL_SYNC_CNT_W'(SYNC_LOSS_CYC));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncMode <= axfl_pkg::SYNC_DRIVEN;
      syncLast <= 1'b0;
      sinceEdge <= `AXFL_SYNC_CNT_W'(SYNC_LOSS_CYC);
      interlockReceive <= 1'b0;
      ampSyncToDrives <= 1'b0;
      syncActive <= 1'b0;
    end else begin
      syncMode <= next_syncMode;
      syncLast <= next_syncLast;
      sinceEdge <= next_sinceEdge;
      interlockReceive <= next_interlock;
      ampSyncToDrives <= next_ampSync;
      syncActive <= next_syncActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one independent channel per axis
  for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
    axfl_axis_channel u_channel (
      .sys_clk(sys_clk),
      .rst(rst),
      .sineIn(sineIn[ax]),
      .cosineIn(cosineIn[ax]),
      .markerIn(markerIn[ax]),
      .hallIn(hallIn[ax]),
      .cwLimitIn(cwLimitIn[ax]),
      .ccwLimitIn(ccwLimitIn[ax]),
      .homeLimitIn(homeLimitIn[ax]),
      .driveFaultIn(driveFaultIn[ax]),
      .enableNIn(enableNIn[ax]),
      .sineP(sineP[ax]),
      .sineN(sineN[ax]),
      .cosineP(cosineP[ax]),
      .cosineN(cosineN[ax]),
      .markerP(markerP[ax]),
      .markerN(markerN[ax]),
      .hallOut(hallOut[ax]),
      .cwLimitOut(cwLimitOut[ax]),
      .ccwLimitOut(ccwLimitOut[ax]),
      .homeLimitOut(homeLimitOut[ax]),
      .faultN(faultN[ax]),
      .hallCodeBad(hallCodeBad[ax]),
      .driveEnable(driveEnable[ax])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] settleCnt;
  logic [1:0] next_settleCnt;
  logic [1:0] settle;
  logic [1:0] next_settle;

  // registered copy of the count arms the checks one edge after it saturates
  always_comb begin
    next_settleCnt = (settleCnt == `AXFL_SETTLE_CYC) ? settleCnt : settleCnt + 2'h1;
    next_settle = settleCnt;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settleCnt <= 2'h0;
      settle <= 2'h0;
    end else begin
      settleCnt <= next_settleCnt;
      settle <= next_settle;
    end
  end

  sequence sendRise_s;
    $rose(interlockSend);
  endsequence

  sequence loopRise_s;
    ##3 interlockReceive;
  endsequence

  interlock_rise_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    sendRise_s |-> loopRise_s)
    else $error("interlock rise not returned in three cycles");

  interlock_level_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    interlockReceive == $past(interlockSend, 3))
    else $error("interlock return differs from send");

  sync_common_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (syncMode == axfl_pkg::SYNC_COMMON) |=> !ampSyncToDrives && !syncActive)
    else $error("sync driven while strapped common");

  sync_pass_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    (syncMode == axfl_pkg::SYNC_DRIVEN) |=> ampSyncToDrives == $past(ampSyncIn, 3))
    else $error("sync not passed to drives");

  sync_loss_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    // an edge arriving at the saturated count legally revives the status
    ((sinceEdge == `AXFL_SYNC_CNT_W'(SYNC_LOSS_CYC)) && !syncEdge) |-> ##1 !syncActive)
    else $error("sync reported active after loss window");

  axes_enable_a: assert property (
    @(posedge sys_clk) disable iff (rst || settle != `AXFL_SETTLE_CYC)
    driveEnable == ~$past(enableNIn, 3))
    else $error("axis enables not independent");

endmodule : axfl_top

// >>> tb_axis_feedback_limit_interface.sv
`timescale 1ns/10ps
`include "axfl_regs.svh"

module tb_axis_feedback_limit_interface;
  localparam int NA = `AXFL_NUM_AXES;
  // short loss window keeps the run brief
  localparam int LOSS = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sendLevel = 1'b0;
  logic syncOn = 1'b0;
  logic syncStrapCommon = 1'b0;
  logic [NA-1:0] enableNCmd = '1;
  logic homeCycle = 1'b0;
  logic [NA-1:0] sineIn = '0, cosineIn = '1, markerIn = '0;
  logic [NA-1:0] cwLimitIn = '0, ccwLimitIn = '0, homeLimitIn = '0;
  logic [NA-1:0] driveFaultIn = '0;
  axfl_pkg::axfl_hall_type [NA-1:0] hallIn = {NA{3'h1}};
  logic interlockSend, ampSyncIn, interlockReceive, ampSyncToDrives, syncActive;
  logic chassisPresent;
  logic [NA-1:0] enableNIn, sineP, sineN, cosineP, cosineN, markerP, markerN;
  logic [NA-1:0] cwLimitOut, ccwLimitOut, homeLimitOut, faultN, driveEnable;
  logic [NA-1:0] hallCodeBad, encoderLoss, cwBlock, ccwBlock, homeFound;
  logic [NA-1:0][7:0] position;
  axfl_pkg::axfl_hall_type [NA-1:0] hallOut;
  int err_count = 0;
  int samples_checked = 0;

  always #50 sys_clk = ~sys_clk;

  axfl_top #(.NUM_AXES(NA), .SYNC_LOSS_CYC(LOSS)) dut (
    .sys_clk, .rst, .interlockSend, .ampSyncIn, .syncStrapCommon, .enableNIn,
    .sineIn, .cosineIn, .markerIn, .hallIn, .cwLimitIn, .ccwLimitIn,
    .homeLimitIn, .driveFaultIn, .interlockReceive, .sineP, .sineN, .cosineP,
    .cosineN, .markerP, .markerN, .hallOut, .cwLimitOut, .ccwLimitOut,
    .homeLimitOut, .faultN, .driveEnable, .ampSyncToDrives, .syncActive,
    .hallCodeBad);

  axfl_ctrl_model #(.NUM_AXES(NA)) ctrl (
    .sys_clk, .rst, .sendLevel, .syncOn, .enableNCmd, .interlockSend,
    .ampSyncIn, .enableNIn, .interlockReceive, .sineP, .sineN, .cosineP,
    .cosineN, .cwLimitOut, .ccwLimitOut, .markerP, .homeLimitOut, .homeCycle,
    .chassisPresent, .encoderLoss, .cwBlock, .ccwBlock, .homeFound, .position);

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // always land just after the edge so inputs never race the sampling
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    cmp({sineP, sineN, driveEnable, faultN}, 16'h0F0F);
    cmp(16'({interlockReceive, ampSyncToDrives, hallCodeBad}), 16'h0000);
  endtask : t_reset

  task t_interlock;
    for (int v = 1; v >= 0; v--) begin
      sendLevel = v[0];
      step(5);
      cmp(16'(interlockReceive), 16'(v));
      cmp(16'(chassisPresent), 16'h0001);
    end
  endtask : t_interlock

  // one axis at a time shows the channels do not leak into each other
  task t_encoder;
    logic [NA-1:0] s, m;
    for (int a = 0; a < NA; a++) begin
      s = NA'(1) << a;
      m = NA'(1) << ((a + 1) % NA);
      sineIn = s;
      cosineIn = ~s;
      markerIn = m;
      step(3);
      cmp({sineP, sineN, cosineP, cosineN}, {s, ~s, ~s, s});
      cmp(16'({markerP, markerN}), 16'({m, ~m}));
      cmp(16'(encoderLoss), 16'h0000);
    end
  endtask : t_encoder

  task t_hall;
    logic [NA-1:0] bad;
    for (int c = 0; c < 8; c++) begin
      for (int a = 0; a < NA; a++) begin
        hallIn[a] = 3'(c + a);
        bad[a] = (3'(c + a) == 3'h0) || (3'(c + a) == 3'h7);
      end
      step(3);
      cmp(16'(hallOut), 16'(hallIn));
      cmp(16'(hallCodeBad), 16'(bad));
    end
  endtask : t_hall

  task t_limits;
    for (int k = 0; k < 2; k++) begin
      cwLimitIn = k ? 4'hA : 4'h5;
      ccwLimitIn = ~cwLimitIn;
      homeLimitIn = k ? 4'h3 : 4'hC;
      step(3);
      cmp({4'h0, cwLimitOut, ccwLimitOut, homeLimitOut},
          {4'h0, cwLimitIn, ccwLimitIn, homeLimitIn});
      cmp(16'({cwBlock, ccwBlock}), 16'({cwLimitIn, ccwLimitIn}));
    end
  endtask : t_limits

  // home cycle: switch arms the search, the next marker zeroes the count;
  // then axes 1:0 step forward and 3:2 backward through three edges
  task t_home;
    sineIn = '0;
    cosineIn = '0;
    markerIn = '0;
    homeLimitIn = '0;
    step(8);
    homeCycle = 1'b1;
    step(8);
    cmp(16'(homeFound), 16'h0000);
    homeLimitIn = '1;
    step(8);
    cmp(16'(homeFound), 16'h000F);
    markerIn = '1;
    step(8);
    homeCycle = 1'b0;
    markerIn = '0;
    homeLimitIn = '0;
    step(8);
    cmp(position[1:0], 16'h0000);
    cmp(position[3:2], 16'h0000);
    sineIn = 4'h3;
    cosineIn = 4'hC;
    step(4);
    sineIn = 4'hF;
    cosineIn = 4'hF;
    step(4);
    sineIn = 4'hC;
    cosineIn = 4'h3;
    step(8);
    cmp(position[1:0], 16'h0303);
    cmp(position[3:2], 16'hFDFD);
    // outside the home cycle switch and marker must leave the count alone
    homeLimitIn = '1;
    markerIn = '1;
    step(8);
    cmp(16'(homeFound), 16'h0000);
    cmp(position[1:0], 16'h0303);
    homeLimitIn = '0;
    markerIn = '0;
  endtask : t_home

  // enable passes one extra edge through the controller pin driver
  task t_enable_fault;
    enableNCmd = 4'h6;
    driveFaultIn = 4'h3;
    step(4);
    cmp(16'(driveEnable), 16'h0009);
    cmp(16'(faultN), 16'h000C);
    enableNCmd = '1;
    driveFaultIn = 4'hC;
    step(4);
    cmp(16'({driveEnable, faultN}), 16'h0003);
  endtask : t_enable_fault

  task t_sync;
    int i;
    syncOn = 1'b1;
    for (i = 0; i < 600 && ampSyncToDrives !== 1'b1; i++) step(1);
    if (ampSyncToDrives !== 1'b1) begin
      cmp(16'(ampSyncToDrives), 16'h0001);
      end_of_test();
    end
    cmp(16'(syncActive), 16'h0001);
    step(LOSS + 5);
    cmp(16'({ampSyncToDrives, syncActive}), 16'h0002);
    // strap common across a full sync period: drives see nothing
    syncStrapCommon = 1'b1;
    for (int n = 0; n < 12; n++) begin
      step(50);
      cmp(16'({ampSyncToDrives, syncActive}), 16'h0000);
    end
    syncStrapCommon = 1'b0;
    syncOn = 1'b0;
  endtask : t_sync

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    step(8);
    t_reset();
    step(8);
    rst = 1'b0;
    step(3);
    t_interlock();
    t_encoder();
    t_hall();
    t_limits();
    t_home();
    t_enable_fault();
    t_sync();
    end_of_test();
  end
endmodule : tb_axis_feedback_limit_interface
